// ===== logic/free_counter.sv
// Purpose: 16-bit free-running timer counter with byte views, wrap flag and timer interrupt.
// Assumes: One clock aclk at 100 MHz; synchronous active-low reset; AXI4-Lite register slave.
// Notes:   Compare and capture channels are kept to registers, flags and their shared enables.
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`include "ftimer_regs.svh"

module free_counter #(
    parameter bit EXT_BONDED     = 1'b1,
    parameter bit CAP_ONE_BONDED = 1'b1,
    parameter bit CAP_TWO_BONDED = 1'b1
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        ext_count_input,
    input  wire logic        capture_input_one,
    input  wire logic        capture_input_two,
    input  wire logic        halt_mode,
    input  wire logic        cpu_int_mask,
    output logic             timer_irq
);
    import ftimer_pkg::*;

    // A missing pin is tied high, so its synchroniser starts high too and shows no false edge after reset.
    localparam state_type STATE_RESET = '{
        count:     `COUNT_RESET,
        presc:     `PRESC_RESET,
        ctl_one:   `CTL_RESET,
        ctl_two:   `CTL_RESET,
        cmp:       {`CMP_RESET, `CMP_RESET},
        cap:       {`CAP_RESET, `CAP_RESET},
        ext_meta:  !EXT_BONDED,
        ext_sync:  !EXT_BONDED,
        ext_prev:  !EXT_BONDED,
        cap_meta:  {!CAP_TWO_BONDED, !CAP_ONE_BONDED},
        cap_sync:  {!CAP_TWO_BONDED, !CAP_ONE_BONDED},
        cap_prev:  {!CAP_TWO_BONDED, !CAP_ONE_BONDED},
        default:   '0
    };

    state_type   state_reg;
    state_type   state_next;
    logic        ext_pin;
    logic [1:0]  cap_pins;
    logic [1:0]  clk_sel;
    logic [2:0]  presc_mask;
    logic        ext_edge;
    logic        tick;
    logic        wrap_evt;
    logic        wr_go;
    logic        rd_go;
    reg_sel_type wr_sel;
    reg_sel_type rd_sel;
    logic        cnt_lo_wr;
    logic        shd_lo_acc;

    function automatic reg_sel_type reg_decode(input logic [7:0] addr);
        case (addr)
            `OFS_CNT_HI:  reg_decode = SEL_CNT_HI;
            `OFS_CNT_LO:  reg_decode = SEL_CNT_LO;
            `OFS_SHD_HI:  reg_decode = SEL_SHD_HI;
            `OFS_SHD_LO:  reg_decode = SEL_SHD_LO;
            `OFS_STATUS:  reg_decode = SEL_STATUS;
            `OFS_CTL_ONE: reg_decode = SEL_CTL_ONE;
            `OFS_CTL_TWO: reg_decode = SEL_CTL_TWO;
            `OFS_CMP_ONE: reg_decode = SEL_CMP_ONE;
            `OFS_CMP_TWO: reg_decode = SEL_CMP_TWO;
            `OFS_CAP_ONE: reg_decode = SEL_CAP_ONE;
            `OFS_CAP_TWO: reg_decode = SEL_CAP_TWO;
            default:      reg_decode = SEL_NONE;
        endcase
    endfunction

    // Missing pins are tied high so that no edge is ever seen on them.
    assign ext_pin  = EXT_BONDED ? ext_count_input : 1'b1;
    assign cap_pins = {CAP_TWO_BONDED ? capture_input_two : 1'b1,
                       CAP_ONE_BONDED ? capture_input_one : 1'b1};

    assign clk_sel = state_reg.ctl_two[`C2_SEL_LO +: 2];
    always_comb begin
        case (clk_sel)
            `SEL_DIV2: presc_mask = `MASK_DIV2;
            `SEL_DIV4: presc_mask = `MASK_DIV4;
            default:   presc_mask = `MASK_DIV8;
        endcase
    end

    // Only the synchronised copies are compared, so a late edge costs one cycle, never a glitch.
    assign ext_edge = (state_reg.ext_sync != state_reg.ext_prev)
                   && (state_reg.ext_sync == state_reg.ctl_two[`C2_EXT_EDGE]);
    // Wait mode is not an input at all: only halt stops the count.
    assign tick = !halt_mode && ((clk_sel == `SEL_EXT) ? ext_edge
                : ((state_reg.presc & presc_mask) == presc_mask));
    assign wrap_evt = tick && (state_reg.count == `COUNT_TOP);

    assign awready = !state_reg.aw_held && !state_reg.bvalid;
    assign wready  = !state_reg.w_held && !state_reg.bvalid;
    assign arready = !state_reg.rvalid;
    assign wr_go   = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
    assign rd_go   = arvalid && arready;
    assign wr_sel  = reg_decode(state_reg.aw_addr);
    assign rd_sel  = reg_decode(araddr);
    assign cnt_lo_wr  = wr_go && state_reg.w_strb[0]
                     && (wr_sel == SEL_CNT_LO || wr_sel == SEL_SHD_LO);
    assign shd_lo_acc = (wr_go && wr_sel == SEL_SHD_LO) || (rd_go && rd_sel == SEL_SHD_LO);

    always_comb begin
        state_next = state_reg;

        state_next.ext_meta = ext_pin;
        state_next.ext_sync = state_reg.ext_meta;
        state_next.ext_prev = state_reg.ext_sync;
        state_next.cap_meta = cap_pins;
        state_next.cap_sync = state_reg.cap_meta;
        state_next.cap_prev = state_reg.cap_sync;

        if (!halt_mode) begin
            state_next.presc = state_reg.presc + `PRESC_STEP;
        end
        if (tick) begin
            state_next.count = state_reg.count + `COUNT_STEP;
        end

        if (awvalid && awready) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            state_next.w_held = 1'b1;
            state_next.w_data = wdata;
            state_next.w_strb = wstrb;
        end
        if (state_reg.bvalid && bready) begin
            state_next.bvalid = 1'b0;
        end

        if (wr_go) begin
            state_next.aw_held = 1'b0;
            state_next.w_held  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            case (wr_sel)
                SEL_CNT_LO: begin
                    if (state_reg.wrap_armed) begin
                        state_next.wrap_flag  = 1'b0;
                        state_next.wrap_armed = 1'b0;
                    end
                end
                SEL_CTL_ONE: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.ctl_one = state_reg.w_data[7:0];
                    end
                end
                SEL_CTL_TWO: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.ctl_two = state_reg.w_data[7:0];
                    end
                end
                default: begin
                end
            endcase
            // Writes to read-only views are accepted and dropped.
            for (int i = 0; i < 2; i++) begin
                if (wr_sel == reg_sel_type'(SEL_CMP_ONE + i)) begin
                    for (int b = 0; b < 2; b++) begin
                        if (state_reg.w_strb[b]) begin
                            state_next.cmp[i][b*8 +: 8] = state_reg.w_data[b*8 +: 8];
                        end
                    end
                    if (state_reg.cmp_armed[i]) begin
                        state_next.cmp_flag[i]  = 1'b0;
                        state_next.cmp_armed[i] = 1'b0;
                    end
                end
                if (wr_sel == reg_sel_type'(SEL_CAP_ONE + i) && state_reg.cap_armed[i]) begin
                    state_next.cap_flag[i]  = 1'b0;
                    state_next.cap_armed[i] = 1'b0;
                end
            end
        end
        if (cnt_lo_wr) begin
            state_next.count = `COUNT_RESET;
            state_next.presc = `PRESC_RESET;
        end

        if (state_reg.rvalid && rready) begin
            state_next.rvalid = 1'b0;
        end
        if (rd_go) begin
            state_next.rvalid = 1'b1;
            state_next.rresp  = `RESP_OKAY;
            state_next.rdata  = '0;
            case (rd_sel)
                SEL_CNT_HI, SEL_SHD_HI: begin
                    state_next.rdata[7:0] = state_reg.count[15:8];
                    // A repeated high read must not refresh the buffered low byte.
                    if (!state_reg.buf_held) begin
                        state_next.low_buf  = state_reg.count[7:0];
                        state_next.buf_held = 1'b1;
                    end
                end
                SEL_CNT_LO, SEL_SHD_LO: begin
                    state_next.rdata[7:0] = state_reg.buf_held ? state_reg.low_buf
                                          : state_reg.count[7:0];
                    state_next.buf_held = 1'b0;
                    if (rd_sel == SEL_CNT_LO && state_reg.wrap_armed) begin
                        state_next.wrap_flag  = 1'b0;
                        state_next.wrap_armed = 1'b0;
                    end
                end
                SEL_STATUS: begin
                    state_next.rdata[`ST_WRAP]        = state_reg.wrap_flag;
                    state_next.rdata[`ST_CMP_LO +: 2] = state_reg.cmp_flag;
                    state_next.rdata[`ST_CAP_LO +: 2] = state_reg.cap_flag;
                    state_next.wrap_armed = state_reg.wrap_armed | state_reg.wrap_flag;
                    state_next.cmp_armed  = state_reg.cmp_armed | state_reg.cmp_flag;
                    state_next.cap_armed  = state_reg.cap_armed | state_reg.cap_flag;
                end
                SEL_CTL_ONE: state_next.rdata[7:0] = state_reg.ctl_one;
                SEL_CTL_TWO: state_next.rdata[7:0] = state_reg.ctl_two;
                SEL_CMP_ONE: state_next.rdata[15:0] = state_reg.cmp[0];
                SEL_CMP_TWO: state_next.rdata[15:0] = state_reg.cmp[1];
                SEL_CAP_ONE: state_next.rdata[15:0] = state_reg.cap[0];
                SEL_CAP_TWO: state_next.rdata[15:0] = state_reg.cap[1];
                default: state_next.rresp = `RESP_SLVERR;
            endcase
            for (int i = 0; i < 2; i++) begin
                if (rd_sel == reg_sel_type'(SEL_CMP_ONE + i) && state_reg.cmp_armed[i]) begin
                    state_next.cmp_flag[i]  = 1'b0;
                    state_next.cmp_armed[i] = 1'b0;
                end
                if (rd_sel == reg_sel_type'(SEL_CAP_ONE + i) && state_reg.cap_armed[i]) begin
                    state_next.cap_flag[i]  = 1'b0;
                    state_next.cap_armed[i] = 1'b0;
                end
            end
        end

        // Hardware sets come last so an event in the clearing cycle is kept.
        if (wrap_evt) begin
            state_next.wrap_flag = 1'b1;
        end
        for (int i = 0; i < 2; i++) begin
            if (tick && state_reg.count == state_reg.cmp[i]) begin
                state_next.cmp_flag[i] = 1'b1;
            end
            if (state_reg.cap_sync[i] != state_reg.cap_prev[i]
                && state_reg.cap_sync[i] == state_reg.ctl_one[`C1_CAP_EDGE_LO + i]) begin
                state_next.cap[i]      = state_reg.count;
                state_next.cap_flag[i] = 1'b1;
            end
        end
    end

    // All state lives here, so a second instance shares nothing and leaves reset in step.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign bvalid = state_reg.bvalid;
    assign bresp  = state_reg.bresp;
    assign rvalid = state_reg.rvalid;
    assign rdata  = state_reg.rdata;
    assign rresp  = state_reg.rresp;

    // The request is a level; it waits on the flags while masked.
    assign timer_irq = !cpu_int_mask && (
        (state_reg.wrap_flag && state_reg.ctl_one[`C1_WRAP_IE])
        || (|state_reg.cmp_flag && state_reg.ctl_one[`C1_CMP_IE])
        || (|state_reg.cap_flag && state_reg.ctl_one[`C1_CAP_IE]));

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    reset_count_a: assert property ($rose(aresetn) |-> state_reg.count == `COUNT_RESET)
        else $error("Count did not leave reset at FFFCh.");
    count_step_a: assert property (tick && !cnt_lo_wr |=> state_reg.count == $past(state_reg.count) + 16'h0001)
        else $error("Count did not advance on a tick.");
    div_two_a: assert property (clk_sel == `SEL_DIV2 && !halt_mode && tick
        ##1 (clk_sel == `SEL_DIV2 && !halt_mode) |-> !tick)
        else $error("Divide-by-two ticked on two cycles in a row.");
    halt_freeze_a: assert property (halt_mode && !cnt_lo_wr |=> $stable(state_reg.count))
        else $error("Count moved during halt.");
    low_write_a: assert property (cnt_lo_wr |=> state_reg.count == `COUNT_RESET)
        else $error("Low byte write did not load FFFCh.");
    wrap_sets_a: assert property (wrap_evt |=> state_reg.wrap_flag
        && (state_reg.count == 16'h0000 || $past(cnt_lo_wr)))
        else $error("Wrap did not set the flag.");
    flag_clear_a: assert property ($fell(state_reg.wrap_flag) |-> $past(state_reg.wrap_armed))
        else $error("Wrap flag cleared without a status read first.");
    shadow_keeps_a: assert property (shd_lo_acc && state_reg.wrap_flag
        && !(wr_go && wr_sel != SEL_SHD_LO) && !(rd_go && rd_sel != SEL_SHD_LO)
        |=> state_reg.wrap_flag && state_reg.wrap_armed == $past(state_reg.wrap_armed))
        else $error("Shadow low access disturbed the wrap flag.");
    latch_hold_a: assert property (state_reg.buf_held
        && !(rd_go && (rd_sel == SEL_CNT_LO || rd_sel == SEL_SHD_LO))
        |=> state_reg.buf_held && $stable(state_reg.low_buf))
        else $error("Latched low byte changed before the low read.");
    irq_gate_a: assert property (cpu_int_mask |-> !timer_irq)
        else $error("Interrupt raised while masked.");
    irq_level_a: assert property (state_reg.wrap_flag && state_reg.ctl_one[`C1_WRAP_IE] && !cpu_int_mask
        |-> timer_irq)
        else $error("Pending wrap did not raise the interrupt.");
    write_answer_a: assert property (wr_go |=> state_reg.bvalid)
        else $error("Write was not answered in one cycle.");

    // The views, the latch and channel one are checked at the edge after the access that moves them.
    shadow_view_a: assert property (rd_go && rd_sel == SEL_SHD_HI
        |=> state_reg.rdata[7:0] == $past(state_reg.count[15:8]))
        else $error("Shadow high byte differs from the count.");
    latch_take_a: assert property (rd_go && rd_sel == SEL_CNT_HI && !state_reg.buf_held
        |=> state_reg.buf_held && state_reg.low_buf == $past(state_reg.count[7:0]))
        else $error("High read did not latch the low byte.");
    live_low_a: assert property (rd_go && rd_sel == SEL_CNT_LO && !state_reg.buf_held
        |=> state_reg.rdata[7:0] == $past(state_reg.count[7:0]))
        else $error("Low read without a latch missed the live count.");
    presc_freeze_a: assert property (halt_mode && !cnt_lo_wr |=> $stable(state_reg.presc))
        else $error("Prescaler moved during halt.");
    irq_off_a: assert property (!state_reg.wrap_flag && !(|state_reg.cmp_flag) && !(|state_reg.cap_flag)
        |-> !timer_irq)
        else $error("Interrupt raised with no flag set.");
    cmp_match_a: assert property (tick && state_reg.count == state_reg.cmp[0]
        |=> state_reg.cmp_flag[0])
        else $error("Compare match did not set its flag.");
    cap_store_a: assert property (state_reg.cap_sync[0] != state_reg.cap_prev[0]
        && state_reg.cap_sync[0] == state_reg.ctl_one[`C1_CAP_EDGE_LO]
        |=> state_reg.cap_flag[0] && state_reg.cap[0] == $past(state_reg.count))
        else $error("Capture edge did not store the count.");

    wrap_seen_c: cover property (wrap_evt);
    flag_cleared_c: cover property (state_reg.wrap_armed ##[1:20] $fell(state_reg.wrap_flag));
    ext_tick_c: cover property (clk_sel == `SEL_EXT && tick);
    latched_read_c: cover property (state_reg.buf_held ##1 !state_reg.buf_held);
    match_seen_c: cover property (tick && state_reg.count == state_reg.cmp[0]);

endmodule

// ===== logic/ftimer_regs.svh
// Purpose: Register offsets, field positions, reset values and codes of the free-running counter.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register.
// Notes:   Definitions only; included by the package and the counter module.
`ifndef FTIMER_REGS_SVH
`define FTIMER_REGS_SVH

`define OFS_CNT_HI      8'h00
`define OFS_CNT_LO      8'h04
`define OFS_SHD_HI      8'h08
`define OFS_SHD_LO      8'h0c
`define OFS_STATUS      8'h10
`define OFS_CTL_ONE     8'h14
`define OFS_CTL_TWO     8'h18
`define OFS_CMP_ONE     8'h1c
`define OFS_CMP_TWO     8'h20
`define OFS_CAP_ONE     8'h24
`define OFS_CAP_TWO     8'h28

`define COUNT_RESET     16'hfffc
`define COUNT_TOP       16'hffff
`define COUNT_STEP      16'h0001
`define CMP_RESET       16'h8000
`define CAP_RESET       16'h0000
`define CTL_RESET       8'h00
`define PRESC_STEP      3'h1
`define PRESC_RESET     3'h0

`define ST_WRAP         7
`define ST_CMP_LO       5
`define ST_CAP_LO       3
`define C1_CAP_EDGE_LO  0
`define C1_WRAP_IE      5
`define C1_CMP_IE       6
`define C1_CAP_IE       7
`define C2_SEL_LO       0
`define C2_EXT_EDGE     2

`define SEL_DIV2        2'h0
`define SEL_DIV4        2'h1
`define SEL_DIV8        2'h2
`define SEL_EXT         2'h3
`define MASK_DIV2       3'h1
`define MASK_DIV4       3'h3
`define MASK_DIV8       3'h7

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ===== logic/ftimer_pkg.sv
// Purpose: Types shared by the free-running counter.
// Assumes: Constants come from ftimer_regs.svh.
// Notes:   The whole state of the counter is one packed struct.
`include "ftimer_regs.svh"

package ftimer_pkg;

    typedef enum logic [3:0] {
        SEL_CNT_HI  = 4'h0,
        SEL_CNT_LO  = 4'h1,
        SEL_SHD_HI  = 4'h2,
        SEL_SHD_LO  = 4'h3,
        SEL_STATUS  = 4'h4,
        SEL_CTL_ONE = 4'h5,
        SEL_CTL_TWO = 4'h6,
        SEL_CMP_ONE = 4'h7,
        SEL_CMP_TWO = 4'h8,
        SEL_CAP_ONE = 4'h9,
        SEL_CAP_TWO = 4'ha,
        SEL_NONE    = 4'hf
    } reg_sel_type;

    typedef struct packed {
        logic [15:0]      count;
        logic [2:0]       presc;
        logic             ext_meta;
        logic             ext_sync;
        logic             ext_prev;
        logic [1:0]       cap_meta;
        logic [1:0]       cap_sync;
        logic [1:0]       cap_prev;
        logic [7:0]       low_buf;
        logic             buf_held;
        logic             wrap_flag;
        logic             wrap_armed;
        logic [7:0]       ctl_one;
        logic [7:0]       ctl_two;
        logic [1:0][15:0] cmp;
        logic [1:0][15:0] cap;
        logic [1:0]       cmp_flag;
        logic [1:0]       cmp_armed;
        logic [1:0]       cap_flag;
        logic [1:0]       cap_armed;
        logic             aw_held;
        logic [7:0]       aw_addr;
        logic             w_held;
        logic [31:0]      w_data;
        logic [3:0]       w_strb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } state_type;

endpackage

// ===== dv/sixteen_bit_free_running_counter_test.sv
// Purpose: Self-checking bench of the free-running counter through its register bus.
// Assumes: halt_mode freezes count and prescaler, so a run of M cycles gives exactly M/N ticks.
// Notes:   Capture pin two stays low and all strobes stay set; one scenario drives capture pin one.
`include "ftimer_regs.svh"
`define CHK(n, e, g) compare(n, 32'(e), 32'(g))

module sixteen_bit_free_running_counter_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata = 32'h0;
    logic        wvalid = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready = 1'b0;
    logic [7:0]  araddr = 8'h00;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready = 1'b0;
    logic        ext = 1'b0;
    logic        cap_pin = 1'b0;
    logic        halt_mode = 1'b1;
    logic        cpu_int_mask = 1'b1;
    logic        timer_irq;
    int          fail_count = 0;
    int          check_count = 0;

    free_counter i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ext_count_input(ext), .capture_input_one(cap_pin), .capture_input_two(1'b0),
        .halt_mode(halt_mode), .cpu_int_mask(cpu_int_mask), .timer_irq(timer_irq));

    always #5 aclk = ~aclk;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic compare(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic timed_out();
        fail_count++;
        $display("FAIL bus answer expected within 64 cycles seen none");
        give_verdict();
    endtask

    // Address and data are offered together and each is dropped at its own handshake edge.
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                bready <= 1'b0;
                `CHK("write response", er, bresp);
                return;
            end
        end
        timed_out();
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                return;
            end
        end
        timed_out();
    endtask

    task automatic chk_read(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        bus_read(a, d, r);
        `CHK(n, e, d);
        `CHK("read response", `RESP_OKAY, r);
    endtask

    task automatic run_free(input int m);
        @(posedge aclk);
        halt_mode <= 1'b0;
        repeat (m) @(posedge aclk);
        halt_mode <= 1'b1;
    endtask

    task automatic reset_values();
        logic [7:0]  a [9] = '{`OFS_CNT_HI, `OFS_CNT_LO, `OFS_STATUS, `OFS_CTL_ONE, `OFS_CTL_TWO,
                               `OFS_CMP_ONE, `OFS_CMP_TWO, `OFS_CAP_ONE, `OFS_CAP_TWO};
        logic [31:0] e [9] = '{32'hff, 32'hfc, 32'h0, 32'h0, 32'h0, 32'h8000, 32'h8000, 32'h0, 32'h0};
        for (int i = 0; i < 9; i++) chk_read("reset value", a[i], e[i]);
        `CHK("irq after reset", 1'b0, timer_irq);
    endtask

    // Each divisor runs 64 cycles from FFFCh, so every one of them wraps and sets the flag.
    task automatic divisors();
        for (int s = 0; s < 3; s++) begin
            bus_write(`OFS_CTL_TWO, 32'(s), `RESP_OKAY);
            bus_write(`OFS_SHD_LO, 32'h0, `RESP_OKAY);
            run_free(64);
            chk_read("count high", `OFS_SHD_HI, 32'(8'(16'(16'hfffc + 64 / (2 << s)) >> 8)));
            chk_read("count low", `OFS_SHD_LO, 32'(8'(16'hfffc + 64 / (2 << s))));
        end
    endtask

    task automatic flag_and_irq();
        bus_write(`OFS_CTL_ONE, 32'h20, `RESP_OKAY);
        @(posedge aclk);
        `CHK("irq while masked", 1'b0, timer_irq);
        cpu_int_mask <= 1'b0;
        @(posedge aclk);
        `CHK("irq pending released", 1'b1, timer_irq);
        chk_read("count low unarmed", `OFS_CNT_LO, 32'h04);
        `CHK("irq kept without arming", 1'b1, timer_irq);
        chk_read("status wrap", `OFS_STATUS, 32'h80);
        chk_read("shadow low", `OFS_SHD_LO, 32'h04);
        `CHK("irq after shadow low", 1'b1, timer_irq);
        chk_read("count low armed", `OFS_CNT_LO, 32'h04);
        `CHK("irq after clear", 1'b0, timer_irq);
        chk_read("status cleared", `OFS_STATUS, 32'h0);
    endtask

    task automatic latch_read();
        bus_write(`OFS_CTL_TWO, 32'h0, `RESP_OKAY);
        bus_write(`OFS_CNT_LO, 32'h0, `RESP_OKAY);
        chk_read("first high", `OFS_SHD_HI, 32'hff);
        run_free(8);
        chk_read("second high", `OFS_CNT_HI, 32'h00);
        chk_read("buffered low", `OFS_CNT_LO, 32'hfc);
        chk_read("live low", `OFS_SHD_LO, 32'h00);
        `CHK("irq on wrap", 1'b1, timer_irq);
    endtask

    // Three toggles five cycles apart: two edges of the chosen kind, one of the other.
    task automatic ext_edges(input logic rising);
        bus_write(`OFS_CTL_TWO, {29'h0, rising, 2'h3}, `RESP_OKAY);
        bus_write(`OFS_CNT_LO, 32'h0, `RESP_OKAY);
        @(posedge aclk);
        halt_mode <= 1'b0;
        for (int t = 0; t < 3; t++) begin
            repeat (5) @(posedge aclk);
            ext <= ~ext;
        end
        repeat (8) @(posedge aclk);
        halt_mode <= 1'b1;
        chk_read("external high", `OFS_SHD_HI, 32'hff);
        chk_read("external low", `OFS_SHD_LO, 32'hfe);
    endtask

    // Waking by reset drops the halted count, the flag and the clock select back to their reset values.
    task automatic reset_wake();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk_read("count high after reset", `OFS_CNT_HI, 32'hff);
        chk_read("count low after reset", `OFS_CNT_LO, 32'hfc);
        chk_read("status after reset", `OFS_STATUS, 32'h0);
        chk_read("clock select after reset", `OFS_CTL_TWO, 32'h0);
    endtask

    // Three ticks from FFFCh pass the compare value; a rising capture edge then stores the held FFFFh.
    task automatic cmp_capture();
        bus_write(`OFS_CTL_ONE, 32'h01, `RESP_OKAY);
        bus_write(`OFS_CMP_ONE, 32'hfffe, `RESP_OKAY);
        bus_write(`OFS_CNT_LO, 32'h0, `RESP_OKAY);
        run_free(6);
        @(posedge aclk);
        cap_pin <= 1'b1;
        repeat (5) @(posedge aclk);
        chk_read("channel flags", `OFS_STATUS, 32'h28);
        `CHK("irq without enables", 1'b0, timer_irq);
        chk_read("capture one", `OFS_CAP_ONE, 32'hffff);
        chk_read("compare one", `OFS_CMP_ONE, 32'hfffe);
        chk_read("channel flags cleared", `OFS_STATUS, 32'h0);
    endtask

    task automatic unmapped();
        logic [31:0] d;
        logic [1:0]  r;
        bus_write(8'h3c, 32'h5a, `RESP_SLVERR);
        bus_read(8'h3c, d, r);
        `CHK("unmapped response", `RESP_SLVERR, r);
        `CHK("unmapped data", 32'h0, d);
    endtask

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        reset_values();
        divisors();
        flag_and_irq();
        latch_read();
        ext_edges(1'b1);
        ext_edges(1'b0);
        reset_wake();
        cmp_capture();
        unmapped();
        give_verdict();
    end
endmodule
